// ==== pkg/swc_pkg.sv ====
// Package for the sleep and wake-up controller: constants and carriers
package swc_pkg;

    // Program counter width and fixed addresses
    localparam int PC_W = 13;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [13:0] ID_BASE = 14'h2000;
    localparam logic [13:0] ID_LAST = 14'h2003;
    localparam int ID_DEPTH = 4;
    localparam int ID_W = 14;
    localparam int PM_AW = 11;
    localparam int WORD_W = 14;

    // Start-up wait in oscillator periods; clk_in is taken as the oscillator
    localparam int OST_PERIODS = 1024;
    localparam int OST_CYCLES = OST_PERIODS;
    localparam int OST_W = 11;

    // Dummy cycles inserted before the vector after wake-up
    localparam int DUMMY_CYCLES = 2;

    // Flag reset values (active-low status flags read 1 after reset)
    localparam logic TIMEOUT_N_RST = 1'b1;
    localparam logic POWER_DOWN_N_RST = 1'b1;

    // Sequencer states
    typedef enum logic [2:0] {
        SWC_RUN = 3'b000,
        SWC_SLEEP = 3'b001,
        SWC_OST = 3'b010,
        SWC_INLINE = 3'b011,
        SWC_DUMMY = 3'b100
    } swc_state_e;

    // Instruction sequencer commands toward the block
    typedef struct packed {
        logic sleep_exec;
        logic wdt_clear_exec;
        logic retfie_exec;
        logic [PC_W-1:0] pc;
    } swc_cmd_s;

    // Steering back to the instruction sequencer
    typedef struct packed {
        logic load_pc;
        logic [PC_W-1:0] pc_value;
        logic push_stack;
        logic [PC_W-1:0] push_value;
        logic prefetch;
        logic [PC_W-1:0] prefetch_addr;
        logic hold;
    } swc_seq_s;

endpackage

// ==== core/swc_id_mem.sv ====
// Four identification words, readable and writable in program mode only
`timescale 1ns/100ps
module swc_id_mem (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Access port
    input wire logic wr_en_in,
    input wire logic [1:0] addr_in,
    input wire logic [swc_pkg::ID_W-1:0] wr_data_in,
    output logic [swc_pkg::ID_W-1:0] rd_data_out
);
    import swc_pkg::*;

    logic [ID_W-1:0] mem_r [ID_DEPTH];

    // Storage write
    always_ff @(posedge clk_in)
    begin
        if (wr_en_in)
            mem_r[addr_in] <= wr_data_in;
    end

    // Registered read data
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            rd_data_out <= 14'h0000;
        else
            rd_data_out <= mem_r[addr_in];
    end
endmodule // swc_id_mem

// ==== core/swc_sleep_ctrl.sv ====
// Sleep entry, wake-up sequencing and program/verify access
// Notes on behaviour
// - Interrupt entry saves only return address on stack; W and status untouched.
// - In sleep all on-chip clocks stop; peripherals cannot raise interrupts. The code still wakes from sleep on any periph_flag_in whose enable is set.
// - Sleep instruction prefetches instruction at PC plus one.
// - Wake needs individual enable set; global enable does not matter.
// - Global enable clear: resume in-line after sleep, no vector.
// - Global enable set: run next instruction, then branch to 0004h.
// - Pending enabled flag before sleep makes sleep a no-op, flags untouched.
// - Interrupt during or after sleep: complete sleep effects, wake at once.
// - Power-down flag stays set after a sleep executed as no-op.
// - Program memory readable for verify while code protection unprogrammed.
// - Four ID words at 2000h-2003h, only accessible in program mode.
// - Serial programming uses one clock and one data line.
// - Edge interrupt flag set on chosen edge, can wake if enabled.
// - Wait 1024 oscillator periods before resuming after wake-up; code waits only when crystal_mode_in is set.
// - Taking interrupt clears global enable, pushes return, loads 0004h.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module swc_sleep_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Instruction sequencer
    input wire swc_pkg::swc_cmd_s cmd_in,
    input wire logic instr_done_in,
    output swc_pkg::swc_seq_s seq_out,
    // Interrupt sources (peripheral flag and enable pairs)
    input wire logic [6:0] periph_flag_in,
    input wire logic [6:0] periph_enable_in,
    // External edge interrupt pin and controls
    input wire logic ext_pin_in,
    input wire logic ext_edge_polarity_in,
    input wire logic ext_edge_irq_enable_in,
    input wire logic ext_flag_clear_in,
    // Global enable software write
    input wire logic gie_set_in,
    input wire logic gie_clear_in,
    // Oscillator mode: crystal modes need start-up wait
    input wire logic crystal_mode_in,
    // Status outputs
    output logic global_irq_enable_out,
    output logic ext_edge_irq_flag_out,
    output logic timeout_flag_n_out,
    output logic power_down_flag_n_out,
    output logic watchdog_clear_out,
    output logic clocks_stopped_out,
    output logic asleep_out,
    // Program/verify port, parallel face of the two-wire serial loader
    input wire logic prog_mode_in,
    input wire logic code_protect_in,
    input wire logic [13:0] prog_addr_in,
    input wire logic prog_wr_in,
    input wire logic [swc_pkg::WORD_W-1:0] prog_wr_data_in,
    input wire logic [swc_pkg::WORD_W-1:0] pm_data_in,
    output logic [swc_pkg::PM_AW-1:0] pm_addr_out,
    output logic [swc_pkg::WORD_W-1:0] prog_rd_data_out,
    output logic prog_rd_valid_out
);
    import swc_pkg::*;

    swc_state_e state_r;
    swc_state_e state_nxt;
    logic [OST_W-1:0] ost_cnt_r;
    logic [1:0] dummy_cnt_r;
    logic pin_r;
    logic pin_ok_r;
    logic ext_flag_r;
    logic gie_r;
    logic to_n_r;
    logic pd_n_r;
    logic [PC_W-1:0] ret_pc_r;
    logic wake_req;
    logic edge_seen;
    logic sleep_real;
    logic sleep_nop;
    logic take_irq;
    logic id_sel;
    logic [ID_W-1:0] id_rd;

    // Any source with both flag and individual enable set
    function automatic logic any_enabled(input logic [6:0] f, input logic [6:0] e,
                                         input logic xf, input logic xe);
        any_enabled = (|(f & e)) | (xf & xe);
    endfunction

    // Wake ignores the global enable by design
    assign wake_req = any_enabled(periph_flag_in, periph_enable_in,
                                  ext_flag_r, ext_edge_irq_enable_in);
    // Pending before sleep turns it into a no-op
    assign sleep_nop = cmd_in.sleep_exec && (state_r == SWC_RUN) && wake_req;
    assign sleep_real = cmd_in.sleep_exec && (state_r == SWC_RUN) && !wake_req;
    // Normal vectoring while running
    assign take_irq = (state_r == SWC_RUN) && gie_r && wake_req && instr_done_in
                      && !cmd_in.sleep_exec;

    // Edge detector on a pin assumed synchronous; blind until history is real
    assign edge_seen = pin_ok_r && (ext_edge_polarity_in ? (ext_pin_in && !pin_r)
                                                         : (!ext_pin_in && pin_r));

    // History trusted only after one real sample, so a pin idling high cannot
    // fake a rising edge out of reset; an edge in that first cycle is lost
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            pin_ok_r <= 1'b0;
        else
            pin_ok_r <= 1'b1;
    end

    // Pin history
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            pin_r <= 1'b0;
        else
            pin_r <= ext_pin_in;
    end

    // Edge flag keeps latching in sleep; set beats clear
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ext_flag_r <= 1'b0;
        else if (edge_seen)
            ext_flag_r <= 1'b1;
        else if (ext_flag_clear_in)
            ext_flag_r <= 1'b0;
    end

    // Global enable: cleared on vector, set by return or software
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            gie_r <= 1'b0;
        else if (take_irq || (state_r == SWC_DUMMY && dummy_cnt_r == 2'h0))
            gie_r <= 1'b0;
        else if (cmd_in.retfie_exec || gie_set_in)
            gie_r <= 1'b1;
        else if (gie_clear_in)
            gie_r <= 1'b0;
    end

    // Status flags: sleep clears power-down, sets timeout; no-op leaves both
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            to_n_r <= TIMEOUT_N_RST;
            pd_n_r <= POWER_DOWN_N_RST;
        end
        else if (sleep_real)
        begin
            to_n_r <= 1'b1;
            pd_n_r <= 1'b0;
        end
        else if (cmd_in.wdt_clear_exec)
        begin
            to_n_r <= 1'b1;
            pd_n_r <= 1'b1;
        end
    end

    // Watchdog clear pulse only from a completed sleep or clear instruction
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            watchdog_clear_out <= 1'b0;
        else
            watchdog_clear_out <= sleep_real || cmd_in.wdt_clear_exec;
    end

    // Return address captured at sleep for vector after wake
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ret_pc_r <= 13'h0000;
        else if (sleep_real)
            ret_pc_r <= PC_W'(cmd_in.pc + 13'h0002);
        else if (take_irq)
            ret_pc_r <= PC_W'(cmd_in.pc + 13'h0001);
    end

    // Next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SWC_RUN:
                if (sleep_real)
                    state_nxt = SWC_SLEEP;
            SWC_SLEEP:
                if (wake_req)
                    state_nxt = crystal_mode_in ? SWC_OST : SWC_INLINE;
            SWC_OST:
                if (ost_cnt_r == OST_W'(OST_CYCLES - 1))
                    state_nxt = SWC_INLINE;
            SWC_INLINE:
                if (instr_done_in)
                    state_nxt = gie_r ? SWC_DUMMY : SWC_RUN;
            SWC_DUMMY:
                if (dummy_cnt_r == 2'(DUMMY_CYCLES - 1))
                    state_nxt = SWC_RUN;
            default:
                state_nxt = SWC_RUN;
        endcase
    end

    // State register
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            state_r <= SWC_RUN;
        else
            state_r <= state_nxt;
    end

    // Start-up counter runs only in the wait state
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ost_cnt_r <= 11'h000;
        else if (state_r == SWC_OST)
            ost_cnt_r <= OST_W'(ost_cnt_r + 11'h001);
        else
            ost_cnt_r <= 11'h000;
    end

    // Dummy cycle counter
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            dummy_cnt_r <= 2'h0;
        else if (state_r == SWC_DUMMY)
            dummy_cnt_r <= 2'(dummy_cnt_r + 2'h1);
        else
            dummy_cnt_r <= 2'h0;
    end

    // Sequencer steering; only the PC goes to the stack, nothing else
    always_comb
    begin
        seq_out = '0;
        seq_out.prefetch = sleep_real || sleep_nop;
        seq_out.prefetch_addr = PC_W'(cmd_in.pc + 13'h0001);
        seq_out.hold = (state_r == SWC_SLEEP) || (state_r == SWC_OST)
                       || (state_r == SWC_DUMMY);
        if (take_irq)
        begin
            seq_out.load_pc = 1'b1;
            seq_out.pc_value = IRQ_VECTOR;
            seq_out.push_stack = 1'b1;
            seq_out.push_value = PC_W'(cmd_in.pc + 13'h0001);
        end
        else if (state_r == SWC_DUMMY && dummy_cnt_r == 2'h0)
        begin
            seq_out.load_pc = 1'b1;
            seq_out.pc_value = IRQ_VECTOR;
            seq_out.push_stack = 1'b1;
            seq_out.push_value = ret_pc_r;
        end
    end

    // Status outputs
    assign global_irq_enable_out = gie_r;
    assign ext_edge_irq_flag_out = ext_flag_r;
    assign timeout_flag_n_out = to_n_r;
    assign power_down_flag_n_out = pd_n_r;
    assign asleep_out = (state_r == SWC_SLEEP);
    assign clocks_stopped_out = (state_r == SWC_SLEEP);

    // Program/verify decode; ID space only in program mode
    assign id_sel = prog_mode_in && (prog_addr_in >= ID_BASE) && (prog_addr_in <= ID_LAST);
    assign pm_addr_out = prog_addr_in[PM_AW-1:0];

    swc_id_mem u_id_mem (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(id_sel && prog_wr_in),
        .addr_in(prog_addr_in[1:0]),
        .wr_data_in(prog_wr_data_in),
        .rd_data_out(id_rd)
    );

    // Read-back path with one cycle of latency
    logic id_sel_r;
    logic pm_ok_r;
    logic [WORD_W-1:0] pm_q_r;
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            id_sel_r <= 1'b0;
            pm_ok_r <= 1'b0;
            pm_q_r <= 14'h0000;
            prog_rd_valid_out <= 1'b0;
        end
        else
        begin
            id_sel_r <= id_sel;
            pm_ok_r <= !code_protect_in;
            pm_q_r <= pm_data_in;
            prog_rd_valid_out <= prog_mode_in && !prog_wr_in;
        end
    end
    assign prog_rd_data_out = id_sel_r ? id_rd : (pm_ok_r ? pm_q_r : 14'h0000);

    // Checks
    a_nop_keeps_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sleep_nop |=> (pd_n_r == $past(pd_n_r)) && (to_n_r == $past(to_n_r))
        && !watchdog_clear_out)
        else $error("sleep no-op changed flags");
    a_sleep_sets_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sleep_real |=> !pd_n_r && to_n_r && watchdog_clear_out)
        else $error("sleep did not update flags");
    a_wake_no_gie: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_r == SWC_SLEEP) && wake_req |=> state_r != SWC_SLEEP)
        else $error("no wake on enabled flag");
    a_prefetch_next: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        cmd_in.sleep_exec && state_r == SWC_RUN |->
        seq_out.prefetch && seq_out.prefetch_addr == PC_W'(cmd_in.pc + 13'h0001))
        else $error("wrong prefetch");
    a_inline_resume: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_r == SWC_INLINE && instr_done_in && !gie_r |=> state_r == SWC_RUN)
        else $error("vectored with global enable clear");
    a_vector_dummy: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_r == SWC_INLINE && instr_done_in && gie_r |=>
        seq_out.load_pc && seq_out.pc_value == IRQ_VECTOR ##1 state_r == SWC_DUMMY
        ##1 state_r == SWC_RUN)
        else $error("vector sequence wrong");
    a_irq_gie_clr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        take_irq |-> seq_out.push_stack ##1 !gie_r)
        else $error("interrupt entry wrong");
    a_edge_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        edge_seen |=> ext_flag_r)
        else $error("edge lost");
    a_ost_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(state_r == SWC_OST) |-> (state_r == SWC_OST)[*8])
        else $error("start-up wait too short");
    // Start-up wait may only end once the counter has run its full length
    a_ost_step: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_r == SWC_OST && ost_cnt_r != OST_W'(OST_CYCLES - 1) |=>
        state_r == SWC_OST && ost_cnt_r == OST_W'($past(ost_cnt_r) + 11'h001))
        else $error("start-up wait cut short");
endmodule // swc_sleep_ctrl

// ==== dv/swc_seq_model.sv ====
// Stand-in for the instruction sequencer on the far side of the controller
`timescale 1ns/100ps
module swc_seq_model
    import swc_pkg::*;
#(
    parameter int DONE_GAP = 3
)(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Steering from the controller
    input wire swc_pkg::swc_seq_s seq_in,
    // Completion toward the controller
    output logic instr_done_out
);
    logic [7:0] gap_r;

    // Completes one instruction every DONE_GAP cycles; a vector load restarts the fetch
    // The in-line instruction after a wake is taken as a no-op, no side effects
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            gap_r <= 8'h00;
            instr_done_out <= 1'b0;
        end
        else
        begin
            instr_done_out <= (gap_r == 8'(DONE_GAP - 1));
            gap_r <= (seq_in.load_pc || gap_r == 8'(DONE_GAP - 1)) ? 8'h00 : gap_r + 8'h01;
        end
    end
endmodule // swc_seq_model

// ==== dv/swc_sleep_ctrl_test.sv ====
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/100ps
module swc_sleep_ctrl_test;
    import swc_pkg::*;
    logic clk_in, sys_rst_in, done, pin, pol, xen, xclr, gset, gclr, xtal;
    logic global_irq_enable, xflag, to_n, pd_n, wdclr, stopped, asleep, pmode, cprot, pwr, pvalid;
    logic [6:0] pflag, pen;
    logic [13:0] paddr, pwdata, pmdata, prd;
    logic [10:0] pmaddr;
    swc_cmd_s cmd;
    swc_seq_s seq;
    int n_fail = 0;
    int check_count = 0;
    int n;

    swc_sleep_ctrl i_swc_sleep_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd),
        .instr_done_in(done), .seq_out(seq), .periph_flag_in(pflag), .periph_enable_in(pen),
        .ext_pin_in(pin), .ext_edge_polarity_in(pol), .ext_edge_irq_enable_in(xen),
        .ext_flag_clear_in(xclr), .gie_set_in(gset), .gie_clear_in(gclr),
        .crystal_mode_in(xtal), .global_irq_enable_out(global_irq_enable), .ext_edge_irq_flag_out(xflag),
        .timeout_flag_n_out(to_n), .power_down_flag_n_out(pd_n), .watchdog_clear_out(wdclr),
        .clocks_stopped_out(stopped), .asleep_out(asleep), .prog_mode_in(pmode),
        .code_protect_in(cprot), .prog_addr_in(paddr), .prog_wr_in(pwr),
        .prog_wr_data_in(pwdata), .pm_data_in(pmdata), .pm_addr_out(pmaddr),
        .prog_rd_data_out(prd), .prog_rd_valid_out(pvalid));

    swc_seq_model #(.DONE_GAP(3)) i_swc_seq_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .seq_in(seq), .instr_done_out(done));

    // 25 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Sleep at address p; prefetch must be visible in the same cycle
    task automatic do_sleep(input logic [12:0] p);
        @(posedge clk_in);
        cmd.sleep_exec <= 1'b1;
        cmd.pc <= p;
        @(negedge clk_in);
        chk("prefetch_addr", 14'(p + 13'h0001), 14'(seq.prefetch_addr));
        chk("prefetch", 14'h0001, 14'(seq.prefetch));
        @(posedge clk_in);
        cmd.sleep_exec <= 1'b0;
        @(negedge clk_in);
    endtask

    task automatic wdt_clr();
        @(posedge clk_in);
        cmd.wdt_clear_exec <= 1'b1;
        @(posedge clk_in);
        cmd.wdt_clear_exec <= 1'b0;
        @(negedge clk_in);
    endtask

    // Bounded wait for a vector load; running out is a failure
    task automatic wait_load(input int lim, output int k);
        k = 0;
        while (seq.load_pc !== 1'b1 && k < lim)
        begin
            @(negedge clk_in);
            k++;
        end
        if (k >= lim)
        begin
            n_fail++;
            results();
        end
    endtask

    task automatic pwrite(input logic [13:0] a, input logic [13:0] d);
        @(posedge clk_in);
        paddr <= a;
        pwdata <= d;
        pwr <= 1'b1;
        @(posedge clk_in);
        pwr <= 1'b0;
    endtask

    task automatic pread(input logic [13:0] a, input logic [13:0] e);
        @(posedge clk_in);
        paddr <= a;
        @(posedge clk_in);
        @(negedge clk_in);
        chk("rd_valid", 14'h0001, 14'(pvalid));
        chk("rd_data", e, prd);
    endtask

    // Main sequence
    initial
    begin
        sys_rst_in = 1'b1;
        cmd = '0;
        {pin, pol, xen, xclr, gset, gclr, xtal, pmode, cprot, pwr} = '0;
        {pflag, pen} = '0;
        {paddr, pwdata, pmdata} = '0;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(negedge clk_in);
        chk("gie_rst", 14'h0000, 14'(global_irq_enable));
        chk("to_n_rst", 14'h0001, 14'(to_n));
        chk("pd_n_rst", 14'h0001, 14'(pd_n));
        // Both edge polarities; the rising edge must be ignored in falling-edge mode
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk_in);
            pol <= p[0];
            pin <= !p[0];
            repeat (3) @(negedge clk_in);
            chk("edge_wrong", 14'h0000, 14'(xflag));
            @(posedge clk_in);
            pin <= p[0];
            repeat (3) @(negedge clk_in);
            chk("edge_flag", 14'h0001, 14'(xflag));
            @(posedge clk_in);
            xclr <= 1'b1;
            @(posedge clk_in);
            xclr <= 1'b0;
        end
        // Real sleep, in-line resume with global enable clear
        wdt_clr();
        do_sleep(13'h0100);
        chk("wd_clear", 14'h0001, 14'(wdclr));
        chk("pd_n_sleep", 14'h0000, 14'(pd_n));
        chk("to_n_sleep", 14'h0001, 14'(to_n));
        chk("stopped", 14'h0001, 14'(stopped));
        chk("hold_sleep", 14'h0001, 14'(seq.hold));
        @(posedge clk_in);
        pflag[2] <= 1'b1;
        repeat (20) @(negedge clk_in);
        chk("masked_wake", 14'h0001, 14'(asleep));
        @(posedge clk_in);
        pflag <= 7'h01;
        pen <= 7'h01;
        n = 0;
        repeat (40)
        begin
            @(negedge clk_in);
            n += int'(seq.load_pc === 1'b1);
        end
        chk("asleep_after", 14'h0000, 14'(asleep));
        chk("inline_vector", 14'h0000, 14'(n));
        chk("hold_run", 14'h0000, 14'(seq.hold));
        @(posedge clk_in);
        pflag <= 7'h00;
        // Pending enabled flag turns sleep into a no-op
        wdt_clr();
        chk("pd_n_wdt", 14'h0001, 14'(pd_n));
        @(posedge clk_in);
        pflag <= 7'h02;
        pen <= 7'h02;
        do_sleep(13'h0200);
        chk("noop_wdclr", 14'h0000, 14'(wdclr));
        chk("noop_pd_n", 14'h0001, 14'(pd_n));
        chk("noop_asleep", 14'h0000, 14'(asleep));
        @(posedge clk_in);
        pflag <= 7'h00;
        // Edge wake in crystal mode with global enable set: start-up wait then vector
        @(posedge clk_in);
        xtal <= 1'b1;
        xen <= 1'b1;
        pin <= 1'b0;
        gset <= 1'b1;
        @(posedge clk_in);
        gset <= 1'b0;
        @(negedge clk_in);
        chk("gie_set", 14'h0001, 14'(global_irq_enable));
        do_sleep(13'h0300);
        @(posedge clk_in);
        pin <= 1'b1;
        repeat (3) @(negedge clk_in);
        chk("flag_in_sleep", 14'h0001, 14'(xflag));
        wait_load(OST_CYCLES + 40, n);
        // Wait is 1024 cycles, plus one to three in-line cycles
        chk("ost_wait", 14'h0001, 14'(n >= OST_CYCLES + 1 && n <= OST_CYCLES + 3));
        chk("vector", 14'(IRQ_VECTOR), 14'(seq.pc_value));
        chk("push", 14'h0001, 14'(seq.push_stack));
        chk("push_value", 14'h0302, 14'(seq.push_value));
        @(negedge clk_in);
        chk("gie_taken", 14'h0000, 14'(global_irq_enable));
        chk("dummy_no_reload", 14'h0000, 14'(seq.load_pc));
        chk("hold_dummy", 14'h0001, 14'(seq.hold));
        // Identification words and program memory verify
        @(posedge clk_in);
        pmode <= 1'b1;
        for (int i = 0; i < 4; i++)
            pwrite(ID_BASE + 14'(i), 14'h0005 + 14'(i));
        pmode <= 1'b0;
        pwrite(14'h2001, 14'h000F);
        pmode <= 1'b1;
        for (int i = 0; i < 4; i++)
            pread(ID_BASE + 14'(i), 14'h0005 + 14'(i));
        @(posedge clk_in);
        pmdata <= 14'h2ABC;
        pread(14'h0123, 14'h2ABC);
        chk("pm_addr", 14'h0123, 14'(pmaddr));
        @(posedge clk_in);
        cprot <= 1'b1;
        pread(14'h0123, 14'h0000);
        results();
    end
endmodule // swc_sleep_ctrl_test
